// >>> rtl/lsst_consts.svh
// Timing constants for the line sensor scan link
`ifndef LSST_CONSTS_SVH
`define LSST_CONSTS_SVH
`define LSST_CLK_NS 100
`define LSST_MIN_PULSE_NS 200
`define LSST_MIN_PULSE_CYC ((`LSST_MIN_PULSE_NS + `LSST_CLK_NS - 1) / `LSST_CLK_NS)
`define LSST_EDGE_ALLOW_NS 20
`define LSST_CLR_GAP_NS 50
`define LSST_CLR_GAP_CYC ((`LSST_CLR_GAP_NS + `LSST_CLK_NS - 1) / `LSST_CLK_NS)
`define LSST_GAP_CYC 1
`define LSST_PIXELS 512
`define LSST_MIN_HALF_CYC 3
`define LSST_MAX_HALF_CYC 50000
`endif

// >>> rtl/lsst_pkg.sv
// Driver state type for the line sensor scan link
package lsst_pkg;
  typedef enum logic [2:0] {
    LSST_IDLE = 3'b000,
    LSST_PH1 = 3'b001,
    LSST_GAP1 = 3'b011,
    LSST_PH2 = 3'b111,
    LSST_GAP2 = 3'b101,
    LSST_WAIT = 3'b100
  } lsst_drv_state_t;
endpackage : lsst_pkg

// >>> rtl/lsst_link_if.sv
// Scan link between timing driver and sensor
`timescale 1ns/1ns
interface lsst_link_if;
  logic phaseOne;
  logic phaseTwo;
  logic scanLaunchPulse;
  logic intClear;
  logic video;
  logic [15:0] videoPixel;
  logic scanDoneFlagOut;
  logic scanDoneFlagOeN;
  wire scanDoneFlagN = scanDoneFlagOeN ? 1'b1 : scanDoneFlagOut;
  modport driver (output phaseOne, phaseTwo, scanLaunchPulse, intClear,
    input video, videoPixel, scanDoneFlagN);
  modport sensor (input phaseOne, phaseTwo, scanLaunchPulse, intClear,
    output video, videoPixel, scanDoneFlagOut, scanDoneFlagOeN);
endinterface : lsst_link_if

// >>> rtl/lsst_sensor.sv
// Sensor end: shift register, pixel output and end-of-scan
`timescale 1ns/1ns
`include "lsst_consts.svh"
module lsst_sensor import lsst_pkg::*; #(
  parameter int PIXELS = `LSST_PIXELS
) (
  input wire logic mclk,
  input wire logic nrst,
  lsst_link_if.sensor link,
  input wire logic [15:0] pixelLevel,
  output logic [15:0] pixelAddr
);
  if (PIXELS < 2 || PIXELS > 65535) begin : g_pixelCheck
    $error("PIXELS out of range");
  end
  // Three-stage pin synchronisers
  logic [2:0] p1S_q, p2S_q, stS_q;
  logic p1_q, p2_q, st_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      p1S_q <= 3'h0; p2S_q <= 3'h0; stS_q <= 3'h0;
    end else begin
      p1S_q <= {p1S_q[1:0], link.phaseOne};
      p2S_q <= {p2S_q[1:0], link.phaseTwo};
      stS_q <= {stS_q[1:0], link.scanLaunchPulse};
    end
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      p1_q <= 1'b0; p2_q <= 1'b0; st_q <= 1'b0;
    end else begin
      if (p1S_q[1] == p1S_q[2]) p1_q <= p1S_q[2];
      if (p2S_q[1] == p2S_q[2]) p2_q <= p2S_q[2];
      if (stS_q[1] == stS_q[2]) st_q <= stS_q[2];
    end
  end
  logic p2Rise, p2Fall;
  assign p2Rise = (p2S_q[1] == p2S_q[2]) && p2S_q[2] && !p2_q;
  assign p2Fall = (p2S_q[1] == p2S_q[2]) && !p2S_q[2] && p2_q;
  // Shift register: armed at the phase-two fall under launch
  logic armed_q, active_q, lastDone_q;
  logic [15:0] addr_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      armed_q <= 1'b0;
      active_q <= 1'b0;
      lastDone_q <= 1'b0;
      addr_q <= 16'h0000;
    end else begin
      if (st_q && p2Fall) begin
        armed_q <= 1'b1;
        active_q <= 1'b0;
        lastDone_q <= 1'b0;
        addr_q <= 16'h0000;
      end else if (p2Rise && armed_q) begin
        armed_q <= 1'b0;
        active_q <= 1'b1;
      end else if (p2Fall && active_q) begin
        // Address moves at the fall so the next level settles before the rise
        if (addr_q == 16'(PIXELS - 1)) begin
          active_q <= 1'b0;
          lastDone_q <= 1'b1;
        end else begin
          addr_q <= addr_q + 16'h0001;
        end
      end else if (p2Rise && lastDone_q) begin
        lastDone_q <= 1'b0;
      end
    end
  end
  assign pixelAddr = addr_q;
  // Pixel presented while phase two is high
  logic vid_q;
  logic [15:0] pix_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      vid_q <= 1'b0;
      pix_q <= 16'h0000;
    end else if (p2Rise && (armed_q || active_q)) begin
      vid_q <= 1'b1;
      pix_q <= pixelLevel;
    end else if (p2Fall) begin
      vid_q <= 1'b0;
    end
  end
  // End-of-scan held low for the phase-two period after the last pixel
  logic eos_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) eos_q <= 1'b0;
    else if (p2Rise && lastDone_q) eos_q <= 1'b1;
    else if (p2Fall) eos_q <= 1'b0;
  end
  assign link.video = vid_q;
  assign link.videoPixel = pix_q;
  assign link.scanDoneFlagOut = 1'b0;
  assign link.scanDoneFlagOeN = !eos_q;
endmodule : lsst_sensor

// >>> rtl/lsst_driver.sv
// Driver end: two-phase scan clock, launch and integrator clear
`timescale 1ns/1ns
`include "lsst_consts.svh"
module lsst_driver import lsst_pkg::*; #(
  parameter int HALF1_CYC = 5,
  parameter int HALF2_CYC = 5,
  parameter int INTEG_CYC = 6000
) (
  input wire logic mclk,
  input wire logic nrst,
  lsst_link_if.driver link,
  input wire logic scanEnable,
  output logic scanDoneSeen,
  output logic [15:0] pixelData,
  output logic pixelValid
);
  localparam int MINW = `LSST_MIN_PULSE_CYC;
  if (HALF1_CYC < MINW || HALF2_CYC < MINW) begin : g_widthCheck
    $error("Phase width below 200 ns");
  end
  if (HALF1_CYC + HALF2_CYC + 2 * `LSST_GAP_CYC < `LSST_MIN_HALF_CYC * 2 ||
      HALF1_CYC + HALF2_CYC > `LSST_MAX_HALF_CYC * 2) begin : g_rateCheck
    $error("Scan rate out of range");
  end
  if (HALF1_CYC + HALF2_CYC + 2 * `LSST_GAP_CYC <= 10 && HALF1_CYC != HALF2_CYC) begin : g_dutyCheck
    $error("Widths must match at 1 MHz or more");
  end
  if (HALF2_CYC < HALF1_CYC) begin : g_orderCheck
    $error("Phase two narrower than phase one");
  end
  if (HALF2_CYC <= `LSST_CLR_GAP_CYC) begin : g_clearCheck
    $error("Clear cannot follow phase two");
  end
  lsst_drv_state_t state_q;
  logic [31:0] cnt_q, integ_q;
  logic launch_q, launchFell_q, launching_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= LSST_IDLE; cnt_q <= 32'h0;
    end else begin
      unique case (state_q)
        LSST_IDLE: if (scanEnable) begin state_q <= LSST_PH1; cnt_q <= 32'h0; end
        LSST_PH1: if (cnt_q == 32'(HALF1_CYC - 1)) begin
          state_q <= LSST_GAP1; cnt_q <= 32'h0;
        end else cnt_q <= cnt_q + 32'h1;
        LSST_GAP1: begin state_q <= LSST_PH2; cnt_q <= 32'h0; end
        LSST_PH2: if (cnt_q == 32'(HALF2_CYC - 1)) begin
          state_q <= LSST_GAP2; cnt_q <= 32'h0;
        end else cnt_q <= cnt_q + 32'h1;
        LSST_GAP2: begin state_q <= scanEnable ? LSST_PH1 : LSST_WAIT; cnt_q <= 32'h0; end
        LSST_WAIT: begin state_q <= LSST_IDLE; cnt_q <= 32'h0; end
        default: begin state_q <= LSST_IDLE; cnt_q <= 32'h0; end
      endcase
    end
  end
  // Launch spans all of one phase-two high: single fall inside it
  logic eosSync1_q, eosSync2_q, eosSync3_q, eos_q, eosPending_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      launch_q <= 1'b0; launching_q <= 1'b0; launchFell_q <= 1'b0;
    end else begin
      launchFell_q <= 1'b0;
      if (state_q == LSST_GAP1 && !eosPending_q && integ_q == 32'h0 && scanEnable) begin
        launch_q <= 1'b1;
        launching_q <= 1'b1;
      end else if (state_q == LSST_GAP2 && launching_q) begin
        launch_q <= 1'b0;
        launching_q <= 1'b0;
        launchFell_q <= 1'b1;
      end
    end
  end
  // Integration timer and end-of-scan tracking
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) integ_q <= 32'h0;
    else if (launchFell_q) integ_q <= 32'(INTEG_CYC);
    else if (integ_q != 32'h0) integ_q <= integ_q - 32'h1;
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      eosSync1_q <= 1'b1; eosSync2_q <= 1'b1; eosSync3_q <= 1'b1; eos_q <= 1'b0;
    end else begin
      eosSync1_q <= link.scanDoneFlagN;
      eosSync2_q <= eosSync1_q;
      eosSync3_q <= eosSync2_q;
      if (eosSync2_q == eosSync3_q) eos_q <= !eosSync3_q;
    end
  end
  logic eosPrev_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      eosPending_q <= 1'b0; eosPrev_q <= 1'b0;
    end else begin
      eosPrev_q <= eos_q;
      if (launchFell_q) eosPending_q <= 1'b1;
      else if (eos_q && !eosPrev_q) eosPending_q <= 1'b0;
    end
  end
  assign scanDoneSeen = eos_q && !eosPrev_q;
  // Integrator clear tied to phase one, delayed past phase-two fall
  logic clr_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) clr_q <= 1'b0;
    else clr_q <= (state_q == LSST_PH1) && (cnt_q >= 32'(`LSST_CLR_GAP_CYC - 1));
  end
  logic pvalid_q;
  logic [15:0] pdata_q;
  logic vidPrev_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pvalid_q <= 1'b0; pdata_q <= 16'h0000; vidPrev_q <= 1'b0;
    end else begin
      vidPrev_q <= link.video;
      pvalid_q <= link.video && !vidPrev_q;
      if (link.video && !vidPrev_q) pdata_q <= link.videoPixel;
    end
  end
  assign pixelValid = pvalid_q;
  assign pixelData = pdata_q;
  assign link.phaseOne = (state_q == LSST_PH1);
  assign link.phaseTwo = (state_q == LSST_PH2);
  assign link.scanLaunchPulse = launch_q;
  assign link.intClear = clr_q;
endmodule : lsst_driver

// >>> testbench/lsst_link_assertions.sv
// Checker watching the scan link between driver and sensor
`timescale 1ns/1ns
module lsst_link_assertions (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic phaseOne,
  input wire logic phaseTwo,
  input wire logic scanLaunchPulse,
  input wire logic intClear,
  input wire logic video,
  input wire logic scanDoneFlagN
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic [3:0] fallCnt_q;
  logic doneSeen_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) fallCnt_q <= 4'h0;
    else if ($rose(scanLaunchPulse)) fallCnt_q <= 4'h0;
    else if ($fell(phaseTwo) && $past(scanLaunchPulse)) fallCnt_q <= fallCnt_q + 4'h1;
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) doneSeen_q <= 1'b1;
    else if ($rose(scanLaunchPulse)) doneSeen_q <= 1'b0;
    else if (!scanDoneFlagN) doneSeen_q <= 1'b1;
  end
  property p_apart; !(phaseOne && phaseTwo); endproperty
  a_apart: assert property (p_apart) else $error("phases overlap");
  property p_gap; ($fell(phaseOne) || $fell(phaseTwo)) |-> !phaseOne && !phaseTwo; endproperty
  a_gap: assert property (p_gap) else $error("no gap");
  property p_wone; $rose(phaseOne) |-> phaseOne[*2]; endproperty
  a_wone: assert property (p_wone) else $error("phase one short");
  property p_wtwo; $rose(phaseTwo) |-> phaseTwo[*2]; endproperty
  a_wtwo: assert property (p_wtwo) else $error("phase two short");
  property p_lap; $rose(scanLaunchPulse) |-> ##[0:2] (phaseTwo && scanLaunchPulse)[*2]; endproperty
  a_lap: assert property (p_lap) else $error("launch overlap short");
  property p_fall; $fell(scanLaunchPulse) |-> fallCnt_q + {3'h0, $fell(phaseTwo)} == 4'h1; endproperty
  a_fall: assert property (p_fall) else $error("phase two falls under launch");
  property p_video; $rose(video) |-> phaseTwo; endproperty
  a_video: assert property (p_video) else $error("video outside phase two");
  property p_done; $fell(scanDoneFlagN) |-> phaseTwo && !video; endproperty
  a_done: assert property (p_done) else $error("end of scan misplaced");
  property p_clr; $rose(intClear) |-> !$past(phaseTwo) && !phaseTwo; endproperty
  a_clr: assert property (p_clr) else $error("clear too early");
  property p_relaunch; $rose(scanLaunchPulse) |-> doneSeen_q; endproperty
  a_relaunch: assert property (p_relaunch) else $error("launch before end of scan");
endmodule : lsst_link_assertions

// >>> testbench/linear_sensor_scan_timing_tb.sv
// Bench joining driver and sensor ends
`timescale 1ns/1ns
module linear_sensor_scan_timing_tb;
  localparam int H1 = 5;
  localparam int H2 = 5;
  localparam int PIX = 8;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic scanEnable = 1'b0;
  logic [15:0] pixelLevel = 16'h0000;
  logic [15:0] pixelAddr;
  logic [15:0] pixelData;
  logic scanDoneSeen;
  logic pixelValid;
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int nPix = 0;
  int nScans = 0;
  int w1 = 0;
  int w2 = 0;
  lsst_link_if link ();
  lsst_driver #(.HALF1_CYC(H1), .HALF2_CYC(H2), .INTEG_CYC(20)) i_lsst_driver (.mclk(mclk), .nrst(nrst),
    .link(link.driver), .scanEnable(scanEnable), .scanDoneSeen(scanDoneSeen), .pixelData(pixelData),
    .pixelValid(pixelValid));
  lsst_sensor #(.PIXELS(PIX)) i_lsst_sensor (.mclk(mclk), .nrst(nrst), .link(link.sensor),
    .pixelLevel(pixelLevel), .pixelAddr(pixelAddr));
  lsst_link_assertions i_lsst_link_assertions (.mclk(mclk), .nrst(nrst), .phaseOne(link.phaseOne),
    .phaseTwo(link.phaseTwo), .scanLaunchPulse(link.scanLaunchPulse), .intClear(link.intClear),
    .video(link.video), .scanDoneFlagN(link.scanDoneFlagN));
  always #50 mclk = ~mclk;
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic summarize();
    if (fail_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  // Light model, width and pixel monitors
  always @(negedge mclk) begin
    cyc++;
    pixelLevel <= {8'hA5, pixelAddr[7:0]};
    if (link.phaseOne === 1'b1) w1++;
    else if (w1 > 0) begin
      chk("phaseOneWidth", 16'(H1), 16'(w1));
      w1 = 0;
    end
    if (link.phaseTwo === 1'b1) w2++;
    else if (w2 > 0) begin
      chk("phaseTwoWidth", 16'(H2), 16'(w2));
      w2 = 0;
    end
    if (pixelValid === 1'b1) begin
      chk("pixelData", {8'hA5, 8'(nPix)}, pixelData);
      nPix++;
    end
    if (scanDoneSeen === 1'b1) begin
      chk("pixelCount", 16'(PIX), 16'(nPix));
      chk("lastAddr", 16'(PIX - 1), pixelAddr);
      nPix = 0;
      nScans++;
    end
    if (cyc > 1000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    repeat (20) @(negedge mclk);
    chk("resetPhaseOne", 16'h0000, {15'h0, link.phaseOne});
    chk("resetDoneFlag", 16'h0001, {15'h0, link.scanDoneFlagN});
    nrst = 1'b1;
    @(negedge mclk);
    scanEnable = 1'b1;
    while (nScans < 2) @(negedge mclk);
    chk("scanCount", 16'h0002, 16'(nScans));
    scanEnable = 1'b0;
    repeat (40) @(negedge mclk);
    chk("idlePhaseOne", 16'h0000, {15'h0, link.phaseOne});
    chk("idlePhaseTwo", 16'h0000, {15'h0, link.phaseTwo});
    chk("idleLaunch", 16'h0000, {15'h0, link.scanLaunchPulse});
    chk("idleDoneFlag", 16'h0001, {15'h0, link.scanDoneFlagN});
    summarize();
  end
endmodule : linear_sensor_scan_timing_tb
